// ### verilog/var_access_pkg.sv
// Constants and carrier types for the microcontroller variable access port.
// Assumes one clock domain; the register decoder in front of it runs on the same clock.
package var_access_pkg;

  // ****************
  // Register map
  // ****************
  localparam logic [7:0]  REG_VAR_ADDRESS = 8'hC6;
  localparam logic [7:0]  REG_VAR_DATA    = 8'hC8;
  localparam logic [7:0]  REG_BURST_FIRST = 8'hC9;
  localparam logic [7:0]  REG_BURST_LAST  = 8'hD1;
  localparam logic [15:0] ADDRESS_RESET   = 16'h0000;
  localparam logic [15:0] DATA_RESET      = 16'h0000;

  // ****************
  // Address register fields
  // ****************
  localparam int          WIDTH_BIT       = 15;
  localparam int          SEL_HI          = 14;
  localparam int          SEL_LO          = 13;
  localparam int          DRIVER_HI       = 12;
  localparam int          DRIVER_LO       = 8;
  localparam int          OFFSET_HI       = 7;
  localparam int          PHYS_HI         = 14;
  localparam logic [1:0]  LOGICAL_SEL     = 2'h1;
  localparam logic [4:0]  SEQUENCER_ID    = 5'h01;
  localparam int          DRIVER_COUNT    = 32;
  localparam logic [7:0]  BURST_MAX_BYTES = 8'h10;
  localparam logic [7:0]  UPPER_ZERO      = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOOKUP = 2'b01,
    ST_MEM    = 2'b10
  } state_code_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic        byte_sel;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } mem_rsp_t;

endpackage

// ### verilog/driver_base_table.sv
// Table of driver data structure base addresses, one word per driver ID.
// Assumes the microcontroller fills it before any logical access is made.
`timescale 1ns/1ns
module driver_base_table (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        wr_en,
  input  wire logic [4:0]  wr_idx,
  input  wire logic [15:0] wr_data,
  input  wire logic        rd_en,
  input  wire logic [4:0]  rd_idx,
  output logic      [15:0] rd_data
);

  logic [15:0] table_mem [var_access_pkg::DRIVER_COUNT];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      table_mem[wr_idx] <= wr_data;
    end
  end

  // Registered read so the lookup costs exactly one cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else if (rd_en) begin
      rd_data <= table_mem[rd_idx];
    end
  end

endmodule

// ### verilog/mcu_variable_access_port.sv
// Variable access port: address and data registers that reach microcontroller memory.
// Assumes the register decoder and the memory answer both run on mclk.
`timescale 1ns/1ns
module mcu_variable_access_port (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  var_access_pkg::reg_req_t       reg_req,
  output logic      [15:0]               reg_rdata,
  output logic                           reg_rvalid,
  output logic                           reg_busy,
  output var_access_pkg::mem_req_t       mem_out,
  input  var_access_pkg::mem_rsp_t       mem_in,
  input  wire logic                      tbl_wr_en,
  input  wire logic [4:0]                tbl_wr_idx,
  input  wire logic [15:0]               tbl_wr_data
);

  // ****************
  // Decode helpers
  // ****************
  function automatic logic is_logical(input logic [15:0] a);
    return a[var_access_pkg::SEL_HI:var_access_pkg::SEL_LO] == var_access_pkg::LOGICAL_SEL;
  endfunction

  function automatic logic is_data_reg(input logic [7:0] r);
    return (r == var_access_pkg::REG_VAR_DATA) ||
           ((r >= var_access_pkg::REG_BURST_FIRST) && (r <= var_access_pkg::REG_BURST_LAST));
  endfunction

  function automatic logic [15:0] byte_mask(input logic bsel, input logic [15:0] d);
    return bsel ? {var_access_pkg::UPPER_ZERO, d[7:0]} : d;
  endfunction

  typedef struct packed {
    var_access_pkg::state_code_t st;
    logic [15:0]                 var_address;
    logic [15:0]                 rdata;
    logic                        rvalid;
    logic                        busy;
    logic [7:0]                  boff;
    var_access_pkg::mem_req_t    mem;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic        accept;
  logic        data_access;
  logic [7:0]  burst_idx;
  logic [7:0]  req_off;
  logic [15:0] tbl_rdata;

  assign accept      = (s.st == var_access_pkg::ST_IDLE) && (reg_req.rd || reg_req.wr);
  assign data_access = accept && is_data_reg(reg_req.addr);
  assign burst_idx   = (reg_req.addr >= var_access_pkg::REG_BURST_FIRST) ?
                       8'(reg_req.addr - var_access_pkg::REG_BURST_FIRST) : 8'h00;
  // Burst registers walk consecutive bytes or words from the base address
  assign req_off     = s.var_address[var_access_pkg::WIDTH_BIT] ? burst_idx :
                       8'(burst_idx << 1);

  driver_base_table u_table (
    .mclk    (mclk),
    .reset   (reset),
    .wr_en   (tbl_wr_en),
    .wr_idx  (tbl_wr_idx),
    .wr_data (tbl_wr_data),
    .rd_en   (data_access && is_logical(s.var_address)),
    .rd_idx  (s.var_address[var_access_pkg::DRIVER_HI:var_access_pkg::DRIVER_LO]),
    .rd_data (tbl_rdata)
  );

  // ****************
  // Next state
  // ****************
  always_comb begin
    next_s        = s;
    next_s.rvalid = 1'b0;
    unique case (s.st)
      var_access_pkg::ST_IDLE: begin
        if (accept && reg_req.wr && reg_req.addr == var_access_pkg::REG_VAR_ADDRESS) begin
          next_s.var_address = reg_req.wdata;
        end
        if (accept && reg_req.rd && !is_data_reg(reg_req.addr)) begin
          next_s.rvalid = 1'b1;
          next_s.rdata  = (reg_req.addr == var_access_pkg::REG_VAR_ADDRESS) ?
                          s.var_address : var_access_pkg::DATA_RESET;
        end
        if (data_access) begin
          next_s.boff         = req_off;
          next_s.mem.we       = reg_req.wr;
          next_s.mem.byte_sel = s.var_address[var_access_pkg::WIDTH_BIT];
          next_s.mem.wdata    = byte_mask(s.var_address[var_access_pkg::WIDTH_BIT],
                                          reg_req.wdata);
          if (is_logical(s.var_address)) begin
            next_s.st = var_access_pkg::ST_LOOKUP;
          end else begin
            next_s.st      = var_access_pkg::ST_MEM;
            next_s.mem.req = 1'b1;
            next_s.mem.addr = 16'({1'b0, s.var_address[var_access_pkg::PHYS_HI:0]}) +
                              {8'h00, req_off};
          end
        end
      end
      var_access_pkg::ST_LOOKUP: begin
        // Driver base plus an offset of one byte's range plus the burst offset
        next_s.st       = var_access_pkg::ST_MEM;
        next_s.mem.req  = 1'b1;
        next_s.mem.addr = tbl_rdata + {8'h00, s.var_address[var_access_pkg::OFFSET_HI:0]} +
                          {8'h00, s.boff};
      end
      var_access_pkg::ST_MEM: begin
        if (mem_in.ack) begin
          next_s.st      = var_access_pkg::ST_IDLE;
          next_s.mem.req = 1'b0;
          if (!s.mem.we) begin
            next_s.rvalid = 1'b1;
            next_s.rdata  = byte_mask(s.mem.byte_sel, mem_in.rdata);
          end
        end
      end
      default: begin
        next_s.st      = var_access_pkg::ST_IDLE;
        next_s.mem.req = 1'b0;
      end
    endcase
    // Busy is registered so reg_busy leaves a flip-flop directly
    next_s.busy = (next_s.st != var_access_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      s             <= '0;
      s.st          <= var_access_pkg::ST_IDLE;
      s.var_address <= var_access_pkg::ADDRESS_RESET;
      s.rdata       <= var_access_pkg::DATA_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ****************
  // Outputs
  // ****************
  assign reg_rdata  = s.rdata;
  assign reg_rvalid = s.rvalid;
  assign reg_busy   = s.busy;
  assign mem_out    = s.mem;

  // ****************
  // Checks
  // ****************
  a_addr_holds: assert property (@(posedge mclk) disable iff (reset)
    !(accept && reg_req.wr && reg_req.addr == var_access_pkg::REG_VAR_ADDRESS)
    |=> s.var_address == $past(s.var_address))
    else $error("address register changed without a write");

  a_width_follows: assert property (@(posedge mclk) disable iff (reset)
    s.mem.req |-> s.mem.byte_sel == s.var_address[var_access_pkg::WIDTH_BIT])
    else $error("access width differs from address bit 15");

  a_byte_write_mask: assert property (@(posedge mclk) disable iff (reset)
    s.mem.req && s.mem.we && s.mem.byte_sel |-> s.mem.wdata[15:8] == 8'h00)
    else $error("byte write carries an upper byte");

  a_byte_read_zero: assert property (@(posedge mclk) disable iff (reset)
    s.st == var_access_pkg::ST_MEM && mem_in.ack && !s.mem.we && s.mem.byte_sel
    |=> reg_rvalid && reg_rdata[15:8] == 8'h00)
    else $error("byte read upper byte not zero");

  a_phys_direct: assert property (@(posedge mclk) disable iff (reset)
    data_access && !is_logical(s.var_address)
    |=> s.mem.req && s.mem.addr == 16'({1'b0, $past(s.var_address[14:0])}) + {8'h00, s.boff})
    else $error("physical address not used directly");

  a_logical_seq: assert property (@(posedge mclk) disable iff (reset)
    data_access && is_logical(s.var_address)
    |=> s.st == var_access_pkg::ST_LOOKUP ##1 s.st == var_access_pkg::ST_MEM && s.mem.req)
    else $error("logical access skipped driver lookup");

  a_logical_addr: assert property (@(posedge mclk) disable iff (reset)
    s.st == var_access_pkg::ST_LOOKUP
    |=> s.mem.addr == $past(tbl_rdata) + {8'h00, s.var_address[7:0]} + {8'h00, s.boff})
    else $error("logical address not base plus offset");

  a_write_store: assert property (@(posedge mclk) disable iff (reset)
    data_access && reg_req.wr |-> ##[1:2] (s.mem.req && s.mem.we))
    else $error("data write did not reach memory");

  a_burst_span: assert property (@(posedge mclk) disable iff (reset)
    s.mem.req |-> s.boff <= var_access_pkg::BURST_MAX_BYTES)
    else $error("burst offset beyond sixteen bytes");

  a_read_answer: assert property (@(posedge mclk) disable iff (reset)
    s.st == var_access_pkg::ST_MEM && mem_in.ack |=> s.st == var_access_pkg::ST_IDLE && !s.mem.req)
    else $error("memory acknowledge did not end access");

  a_req_held: assert property (@(posedge mclk) disable iff (reset)
    s.mem.req && !mem_in.ack |=> s.mem.req && $stable(s.mem.addr) &&
    $stable(s.mem.wdata) && $stable(s.mem.we))
    else $error("memory request changed before acknowledge");

  a_addr_readback: assert property (@(posedge mclk) disable iff (reset)
    accept && reg_req.rd && reg_req.addr == var_access_pkg::REG_VAR_ADDRESS
    |=> reg_rvalid && reg_rdata == $past(s.var_address))
    else $error("address register read back wrong");

  a_sel_logical: assert property (@(posedge mclk) disable iff (reset)
    s.st == var_access_pkg::ST_LOOKUP |-> is_logical(s.var_address))
    else $error("driver lookup without logical select");

  a_word_read_full: assert property (@(posedge mclk) disable iff (reset)
    s.st == var_access_pkg::ST_MEM && mem_in.ack && !s.mem.we && !s.mem.byte_sel
    |=> reg_rvalid && reg_rdata == $past(mem_in.rdata))
    else $error("word read not passed whole");

  a_write_silent: assert property (@(posedge mclk) disable iff (reset)
    accept && reg_req.wr |=> !reg_rvalid)
    else $error("register write produced a read answer");

  a_idle_no_req: assert property (@(posedge mclk) disable iff (reset)
    !reg_busy |-> !mem_out.req)
    else $error("memory request while port idle");

endmodule

// ### verif/mem_model.sv
// Microcontroller memory seen from the variable access port.
// Assumes mem_out is registered on mclk; wait_n is set by the bench.
`timescale 1ns/1ns
module mem_model (
  input  wire logic                mclk,
  input  var_access_pkg::mem_req_t mem_out,
  input  wire logic [3:0]          wait_n,
  output var_access_pkg::mem_rsp_t mem_in,
  output var_access_pkg::mem_req_t last
);
  logic [3:0] cnt = 4'h0;
  initial mem_in = '0;
  always @(posedge mclk) begin
    // Undriven data toggles so a stale value never passes
    mem_in.rdata <= ~mem_in.rdata;
    mem_in.ack   <= 1'b0;
    if (mem_out.req && !mem_in.ack) begin
      if (cnt == wait_n) begin
        cnt          <= 4'h0;
        mem_in.ack   <= 1'b1;
        last         <= mem_out;
        // Upper byte set even for byte reads
        mem_in.rdata <= mem_out.addr ^ 16'hA5C3;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// ### verif/mcu_variable_access_port_tb.sv
// Self-checking bench for the variable access port.
// Assumes mem_model answers the memory side.
`timescale 1ns/1ns
module mcu_variable_access_port_tb;
  logic                     mclk   = 1'b0;
  logic                     reset  = 1'b1;
  var_access_pkg::reg_req_t req    = '0;
  var_access_pkg::mem_req_t mo;
  var_access_pkg::mem_req_t last;
  var_access_pkg::mem_rsp_t mi;
  logic [15:0]              rdata;
  logic                     rvalid;
  logic                     busy;
  logic                     t_en   = 1'b0;
  logic [4:0]               t_idx  = 5'h00;
  logic [15:0]              t_dat  = 16'h0000;
  logic [3:0]               wait_n = 4'h0;
  logic [15:0]              got;
  int                       bad_count   = 0;
  int                       check_count = 0;

  always #2 mclk = ~mclk;

  mcu_variable_access_port dut_u (.mclk(mclk), .reset(reset), .reg_req(req),
    .reg_rdata(rdata), .reg_rvalid(rvalid), .reg_busy(busy), .mem_out(mo),
    .mem_in(mi), .tbl_wr_en(t_en), .tbl_wr_idx(t_idx), .tbl_wr_data(t_dat));
  mem_model mem_u (.mclk(mclk), .mem_out(mo), .wait_n(wait_n), .mem_in(mi), .last(last));

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", what, exp, seen);
    end
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    @(posedge mclk);
    req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge mclk);
    req <= '0;
    n = 0;
    #1;
    while ((busy === 1'b1 || (!w && rvalid !== 1'b1)) && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("answer", 16'h0000, (n == 50) ? 16'h0001 : 16'h0000);
    got = rdata;
  endtask
  task automatic mchk(input logic [15:0] ad, input logic [1:0] wb, input logic [15:0] wd);
    chk("mem addr", ad, last.addr);
    chk("mem we bsel", {14'h0, wb}, {14'h0, last.we, last.byte_sel});
    if (wb[1]) chk("mem wdata", wd, last.wdata);
  endtask
  task automatic tbl(input logic [4:0] i, input logic [15:0] d);
    @(posedge mclk);
    t_en  <= 1'b1;
    t_idx <= i;
    t_dat <= d;
    @(posedge mclk);
    t_en  <= 1'b0;
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    chk("mem_out idle", 16'h0000, mo.addr);
    op(0, 8'hC6, 16'h0000);
    chk("address reset", 16'h0000, got);
    $display("test reset done");
  endtask
  task automatic t_phys;
    logic [15:0] av [3] = '{16'h1234, 16'h4ABC, 16'h6ABC};
    foreach (av[i]) begin
      op(1, 8'hC6, av[i]);
      op(1, 8'hC8, ~av[i]);
      mchk(av[i], 2'h2, ~av[i]);
      op(0, 8'hC8, 16'h0000);
      mchk(av[i], 2'h0, 16'h0000);
      chk("word read", av[i] ^ 16'hA5C3, got);
      op(0, 8'hC6, 16'h0000);
      chk("address kept", av[i], got);
    end
    // Unmapped write must leave the address alone; unmapped read must clear rdata
    op(1, 8'h10, 16'hFFFF);
    op(0, 8'hC6, 16'h0000);
    chk("unmapped write", 16'h6ABC, got);
    op(0, 8'h10, 16'h0000);
    chk("unmapped read", 16'h0000, got);
    $display("test physical done");
  endtask
  task automatic t_byte;
    op(1, 8'hC6, 16'h8055);
    op(1, 8'hC8, 16'hFF77);
    mchk(16'h0055, 2'h3, 16'h0077);
    op(0, 8'hC8, 16'h0000);
    mchk(16'h0055, 2'h1, 16'h0000);
    chk("byte read", 16'h0096, got);
    $display("test byte done");
  endtask
  task automatic t_logical;
    tbl(var_access_pkg::SEQUENCER_ID, 16'h0300);
    tbl(5'h1F, 16'h1000);
    op(1, 8'hC6, 16'h2110);
    op(0, 8'hC8, 16'h0000);
    mchk(16'h0310, 2'h0, 16'h0000);
    chk("logical read", 16'hA6D3, got);
    op(1, 8'hC6, 16'h3FFF);
    op(1, 8'hC8, 16'h1357);
    mchk(16'h10FF, 2'h2, 16'h1357);
    op(1, 8'hC6, 16'hA110);
    op(1, 8'hC8, 16'h9988);
    mchk(16'h0310, 2'h3, 16'h0088);
    $display("test logical done");
  endtask
  task automatic t_burst;
    wait_n <= 4'h3;
    op(1, 8'hC6, 16'h0100);
    op(0, 8'hC9, 16'h0000);
    mchk(16'h0100, 2'h0, 16'h0000);
    op(0, 8'hD1, 16'h0000);
    mchk(16'h0110, 2'h0, 16'h0000);
    chk("burst read", 16'hA4D3, got);
    op(1, 8'hC6, 16'h8100);
    op(1, 8'hD1, 16'hAB12);
    mchk(16'h0108, 2'h3, 16'h0012);
    $display("test burst done");
  endtask
  task automatic t_midreset;
    op(1, 8'hC6, 16'h0200);
    // Address write lands while the data read is in flight and must be refused
    @(posedge mclk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: 8'hC8, wdata: 16'h0000};
    @(posedge mclk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: 8'hC6, wdata: 16'hFFFF};
    @(posedge mclk);
    req <= '0;
    repeat (10) @(posedge mclk);
    op(0, 8'hC6, 16'h0000);
    chk("busy write refused", 16'h0200, got);
    @(posedge mclk);
    reset <= 1'b1;
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    chk("mem_out after reset", 16'h0000, mo.addr);
    op(0, 8'hC6, 16'h0000);
    chk("address after reset", 16'h0000, got);
    $display("test reset again done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    #80000;
    bad_count++;
    test_done;
  end
  initial begin
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    t_reset;
    t_phys;
    t_byte;
    t_logical;
    t_burst;
    t_midreset;
    test_done;
  end
endmodule
